/* File: src/status_byte_pkg.sv */
// Constants and types shared by the status byte and service request block.
package status_byte_pkg;

  // ==========================================================================
  // Status byte bit positions
  // ==========================================================================
  localparam int STATUS_W = 8;
  localparam int BIT_TRIG_READY = 0;
  localparam int BIT_NOTICE = 1;
  localparam int BIT_SWEEP_DONE = 2;
  localparam int BIT_UNUSED_LO = 3;
  localparam int BIT_CMD_DONE = 4;
  localparam int BIT_ERROR = 5;
  localparam int BIT_SRQ = 6;
  localparam int BIT_UNUSED_HI = 7;

  // Bits that take part in the mask comparison: all but 7, 6 and 3.
  localparam logic [7:0] COMPARE_BITS = 8'h37;
  // Bits that the mask command may store: all but the unused 7 and 3.
  localparam logic [7:0] MASK_WRITABLE = 8'h77;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] RESP_RESET = 8'h00;

  // ==========================================================================
  // Host command codes
  // ==========================================================================
  localparam int CMD_W = 2;
  localparam logic [1:0] STATUS_QUERY_CMD = 2'h0;
  localparam logic [1:0] REQUEST_MASK_CMD = 2'h1;
  localparam logic [1:0] TAKE_SWEEP_CMD = 2'h2;
  localparam logic [1:0] FETCH_SWEEP_CMD = 2'h3;

  // ==========================================================================
  // Sweep sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_ARMED = 3'b010,
    SW_RUN = 3'b100
  } sweep_state_t;

endpackage

/* File: src/status_byte_service_request.sv */
// Status byte, service request mask and single sweep trigger sequencer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Eight-bit status byte, one bit per condition.
// - A satisfied condition sets its status bit.
// - Mask register shares the status bit layout.
// - Status matching mask raises a service request.
// - Bit 6 never affects service request generation.
// - Bit 6 records that a request occurred.
// - Bit 5 shows an error is held.
// - Bit 4 set when a command finishes.
// - Bit 2 set when a sweep completes.
// - Bit 1 shows a displayed notice.
// - Bit 0 shows ready for sweep trigger.
// - Host queries status and loads the mask.
// - Single mode: one sweep per demand, when triggered.
module status_byte_service_request (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic [7:0] cmd_data,
  output logic resp_valid,
  output logic [7:0] resp_data,
  output logic srq_req,
  input wire logic error_present,
  input wire logic not_calibrated_notice,
  input wire logic not_corrected_notice,
  input wire logic zeroing_notice,
  input wire logic ext_cmd_done,
  input wire logic single_mode,
  input wire logic sweep_key,
  input wire logic trig_cond,
  input wire logic sweep_end,
  output logic sweep_start,
  output logic sweep_busy
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [7:0] mask;
    logic cmd_done;
    logic sweep_done;
    logic srq;
    status_byte_pkg::sweep_state_t sweep;
    logic take_pending;
    logic resp_valid;
    logic [7:0] resp_data;
    logic start;
    logic key_s1;
    logic key_s2;
    logic key_s3;
  } state_t;

  localparam state_t STATE_RESET = '{
    mask: status_byte_pkg::MASK_RESET,
    cmd_done: 1'b0,
    sweep_done: 1'b0,
    srq: 1'b0,
    sweep: status_byte_pkg::SW_IDLE,
    take_pending: 1'b0,
    resp_valid: 1'b0,
    resp_data: status_byte_pkg::RESP_RESET,
    start: 1'b0,
    key_s1: 1'b0,
    key_s2: 1'b0,
    key_s3: 1'b0
  };

  state_t st_q;
  state_t st_d;

  logic [7:0] status;
  logic notice;
  logic armed;
  logic hit;
  logic query;
  logic mask_wr;
  logic demand;
  logic key_press;
  logic sweep_fin;

  // ==========================================================================
  // Status byte assembly
  // ==========================================================================
  // Level conditions are shown live; event conditions are held until the
  // next status query so that a host polling slowly still sees them.
  assign notice = not_calibrated_notice | not_corrected_notice | zeroing_notice;
  assign armed = (st_q.sweep == status_byte_pkg::SW_ARMED);

  always_comb begin
    status = 8'h00;
    status[status_byte_pkg::BIT_TRIG_READY] = armed;
    status[status_byte_pkg::BIT_NOTICE] = notice;
    status[status_byte_pkg::BIT_SWEEP_DONE] = st_q.sweep_done;
    status[status_byte_pkg::BIT_CMD_DONE] = st_q.cmd_done;
    status[status_byte_pkg::BIT_ERROR] = error_present;
    status[status_byte_pkg::BIT_SRQ] = st_q.srq;
  end

  // A request is raised when any compared status bit meets its mask bit.
  // Bit 6 and the unused bits are left out of the comparison.
  assign hit = |(status & st_q.mask & status_byte_pkg::COMPARE_BITS);

  // ==========================================================================
  // Command decode
  // ==========================================================================
  assign query = cmd_valid && (cmd_code == status_byte_pkg::STATUS_QUERY_CMD);
  assign mask_wr = cmd_valid && (cmd_code == status_byte_pkg::REQUEST_MASK_CMD);
  assign key_press = st_q.key_s2 && !st_q.key_s3;
  assign demand = key_press || (cmd_valid && ((cmd_code == status_byte_pkg::TAKE_SWEEP_CMD) ||
                  (cmd_code == status_byte_pkg::FETCH_SWEEP_CMD)));
  assign sweep_fin = (st_q.sweep == status_byte_pkg::SW_RUN) && sweep_end;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    st_d.key_s1 = sweep_key;
    st_d.key_s2 = st_q.key_s1;
    st_d.key_s3 = st_q.key_s2;
    st_d.start = 1'b0;
    st_d.resp_valid = 1'b0;

    // The query returns the byte as it stands, then clears the held events.
    if (query) begin
      st_d.resp_valid = 1'b1;
      st_d.resp_data = status;
      st_d.cmd_done = 1'b0;
      st_d.sweep_done = 1'b0;
      st_d.srq = 1'b0;
    end
    if (mask_wr) begin
      st_d.mask = cmd_data & status_byte_pkg::MASK_WRITABLE;
    end

    // Sweep sequencer.
    unique case (st_q.sweep)
      status_byte_pkg::SW_IDLE: begin
        if (demand || !single_mode) begin
          st_d.sweep = status_byte_pkg::SW_ARMED;
        end
      end
      status_byte_pkg::SW_ARMED: begin
        if (trig_cond) begin
          st_d.sweep = status_byte_pkg::SW_RUN;
          st_d.start = 1'b1;
        end
      end
      status_byte_pkg::SW_RUN: begin
        if (sweep_end) begin
          st_d.sweep = status_byte_pkg::SW_IDLE;
        end
      end
      default: begin
        st_d.sweep = status_byte_pkg::SW_IDLE;
      end
    endcase

    // A sweep command finishes with the sweep it started.
    if (cmd_valid && demand && !key_press) begin
      st_d.take_pending = 1'b1;
    end else if (sweep_fin) begin
      st_d.take_pending = 1'b0;
    end

    // Setting events come last so they win over a clear in the same cycle.
    if (mask_wr || ext_cmd_done || (sweep_fin && st_q.take_pending)) begin
      st_d.cmd_done = 1'b1;
    end
    if (sweep_fin) begin
      st_d.sweep_done = 1'b1;
    end
    if (hit) begin
      st_d.srq = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign resp_valid = st_q.resp_valid;
  assign resp_data = st_q.resp_data;
  assign srq_req = st_q.srq;
  assign sweep_start = st_q.start;
  assign sweep_busy = (st_q.sweep == status_byte_pkg::SW_RUN);

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_unused_zero:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> (resp_data[7] == 1'b0) && (resp_data[3] == 1'b0))
    else $error("Unused status bits read as one.");

  a_error_bit:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> resp_data[5] == $past(error_present))
    else $error("Error bit does not follow the error register.");

  a_query_answer:
  assert property (@(posedge core_clk) disable iff (!nrst)
    query |=> resp_valid)
    else $error("Status query not answered.");

  a_mask_load:
  assert property (@(posedge core_clk) disable iff (!nrst)
    mask_wr |=> st_q.mask == ($past(cmd_data) & 8'h77))
    else $error("Mask register did not take the written value.");

  a_srq_raise:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (|(status & st_q.mask & 8'h37)) |=> srq_req)
    else $error("Matching status did not raise a service request.");

  a_bit6_ignored:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (!srq_req && !(|(status & st_q.mask & 8'hb7))) |=> !srq_req)
    else $error("Service request raised without a matching bit.");

  a_start_trig:
  assert property (@(posedge core_clk) disable iff (!nrst)
    sweep_start |-> $past(trig_cond) && $past(armed) ##1 !sweep_start)
    else $error("Sweep started without trigger or more than once.");

  a_sweep_done:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (sweep_busy && sweep_end) |=> st_q.sweep_done && !sweep_busy)
    else $error("Sweep_done_flag not recorded.");

  a_cmd_done:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (mask_wr || ext_cmd_done) |=> st_q.cmd_done)
    else $error("Command completion not recorded.");

  a_single_once:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (single_mode && sweep_busy && sweep_end && !demand) |=> !armed && !sweep_busy)
    else $error("Single mode swept again without a demand.");

  a_resp_pulse:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> $past(query))
    else $error("Status answer given without a query.");

  a_notice_bit:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> resp_data[1] == ($past(not_calibrated_notice) || $past(not_corrected_notice) ||
      $past(zeroing_notice)))
    else $error("Notice bit does not follow the displayed notices.");

  a_armed_bit:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> resp_data[0] == ($past(st_q.sweep) == status_byte_pkg::SW_ARMED))
    else $error("Trigger ready bit does not follow the sequencer.");

  a_srq_bit:
  assert property (@(posedge core_clk) disable iff (!nrst)
    resp_valid |-> resp_data[6] == $past(srq_req))
    else $error("Request bit does not follow the service request.");

  a_srq_hold:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (srq_req && !query) |=> srq_req)
    else $error("Service request dropped without a status query.");

  a_query_clear:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (query && !(|(status & st_q.mask & 8'h37)) && !ext_cmd_done && !sweep_fin) |=>
      !srq_req && !st_q.cmd_done && !st_q.sweep_done)
    else $error("Status query did not clear the held events.");

  a_mask_unused:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (st_q.mask[7] == 1'b0) && (st_q.mask[3] == 1'b0))
    else $error("Unused mask bits were stored.");

  a_idle_stays:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (single_mode && (st_q.sweep == status_byte_pkg::SW_IDLE) && !demand) |=> !armed)
    else $error("Single mode armed without a demand.");

  a_demand_arms:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (demand && (st_q.sweep == status_byte_pkg::SW_IDLE)) |=> armed)
    else $error("Sweep demand did not arm the trigger.");

  a_start_busy:
  assert property (@(posedge core_clk) disable iff (!nrst)
    sweep_start |-> sweep_busy)
    else $error("Sweep start without a running sweep.");

  a_sticky_cmd:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (st_q.cmd_done && !query) |=> st_q.cmd_done)
    else $error("Command complete bit dropped without a query.");

  a_sticky_sweep:
  assert property (@(posedge core_clk) disable iff (!nrst)
    (st_q.sweep_done && !query) |=> st_q.sweep_done)
    else $error("Sweep_done_flag bit dropped without a query.");

endmodule
`default_nettype wire

/* File: test/host_model.sv */
// Host program model that issues status, mask and sweep commands.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [1:0] cmd_code,
  output logic [7:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 2'h0;
    cmd_data = 8'h00;
  end

  // ==========================================================================
  // Command issue
  // ==========================================================================
  // One command per call, held for exactly one taking edge.
  task automatic issue(input logic [1:0] c, input logic [7:0] dat);
    @(posedge core_clk);
    #1 cmd_valid = 1'b1;
    cmd_code = c;
    cmd_data = dat;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_data = ~dat;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the status byte and service request block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic core_clk, nrst, cmd_valid, resp_valid, srq_req, sweep_start, sweep_busy;
  logic err, ncal, ncor, zero, done_in, single, key, trig, s_end;
  logic [1:0] cmd_code;
  logic [7:0] cmd_data, resp_data, d, m, e8;
  logic [31:0] seed = 32'h9f87;
  logic [31:0] r;
  int tests_run = 0;
  int miscompares = 0;
  int i, n;
  localparam logic [31:0] CORNER = 32'h40882008;

  host_model HOST (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_data(cmd_data));
  status_byte_service_request DUT (.core_clk(core_clk), .nrst(nrst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .resp_valid(resp_valid), .resp_data(resp_data), .srq_req(srq_req),
    .error_present(err), .not_calibrated_notice(ncal), .not_corrected_notice(ncor),
    .zeroing_notice(zero), .ext_cmd_done(done_in), .single_mode(single),
    .sweep_key(key), .trig_cond(trig), .sweep_end(s_end),
    .sweep_start(sweep_start), .sweep_busy(sweep_busy));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected status byte; bits 7 and 3 are always zero.
  function automatic logic [7:0] st(logic s6, logic e, logic c4, logic s2, logic a);
    return {1'b0, s6, e, c4, 1'b0, s2, ncal | ncor | zero, a};
  endfunction

  task automatic query(output logic [7:0] q);
    HOST.issue(2'h0, 8'h00);
    `CHK(resp_valid, 1'b1)
    q = resp_data;
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================================
  // Test sequence
  // ==========================================================================
  initial begin
    {nrst, err, ncal, ncor, zero, done_in, key, trig, s_end} = '0;
    single = 1'b1;
    repeat (12) @(posedge core_clk);
    #1 nrst = 1'b1;
    `CHK({resp_valid, srq_req, sweep_busy}, 3'h0)
    for (i = 0; i < 12; i++) begin
      r = xs();
      {err, ncal, ncor, zero} = r[3:0];
      query(d);
      query(d);
      `CHK(d, st(1'b0, err, 1'b0, 1'b0, 1'b0))
    end
    @(posedge core_clk);
    #1 done_in = 1'b1;
    @(posedge core_clk);
    #1 done_in = 1'b0;
    query(d);
    `CHK(d[4], 1'b1)
    $display("live and sticky status test done");
    for (i = 0; i < 20; i++) begin
      r = xs();
      m = (i < 4) ? CORNER[8 * (i % 4) +: 8] : r[15:8];
      HOST.issue(2'h1, 8'h00);
      query(d);
      {err, ncal, ncor, zero} = r[3:0];
      HOST.issue(2'h1, m);
      repeat (3) @(posedge core_clk);
      #1;
      e8 = st(1'b0, err, 1'b1, 1'b0, 1'b0) & m & 8'h37;
      `CHK(srq_req, |e8)
      query(d);
      `CHK(d[6], |e8)
    end
    $display("service request test done");
    nrst = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'b1;
    `CHK({resp_valid, srq_req, sweep_busy, sweep_start}, 4'h0)
    query(d);
    `CHK(d, st(1'b0, err, 1'b0, 1'b0, 1'b0))
    $display("mid-run reset test done");
    {err, ncal, ncor, zero} = '0;
    HOST.issue(2'h1, 8'h00);
    query(d);
    for (i = 0; i < 3; i++) begin
      if (i < 2) begin
        HOST.issue(2'h2 + 2'(i), 8'h00);
      end else begin
        #1 key = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 key = 1'b0;
      end
      repeat (4) @(posedge core_clk);
      #1;
      query(d);
      `CHK(d[0], 1'b1)
      trig = 1'b1;
      for (n = 0; n < 20 && sweep_start !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      `CHK({sweep_start, sweep_busy}, 2'h3)
      repeat (xs() % 6) @(posedge core_clk);
      #1 s_end = 1'b1;
      @(posedge core_clk);
      #1 s_end = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      `CHK(sweep_busy, 1'b0)
      query(d);
      `CHK(d, st(1'b0, 1'b0, i < 2, 1'b1, 1'b0))
      trig = 1'b0;
    end
    $display("single sweep test done");
    single = 1'b0;
    trig = 1'b1;
    for (i = 0; i < 2; i++) begin
      for (n = 0; n < 20 && sweep_start !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      `CHK({sweep_start, sweep_busy}, 2'h3)
      if (i == 1) begin
        single = 1'b1;
        trig = 1'b0;
      end
      @(posedge core_clk);
      #1 s_end = 1'b1;
      @(posedge core_clk);
      #1 s_end = 1'b0;
    end
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(sweep_busy, 1'b0)
    query(d);
    `CHK(d, st(1'b0, 1'b0, 1'b0, 1'b1, 1'b0))
    $display("continuous sweep test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
